// *** hw/dsp_pkg.sv ***
// Package: register map, field positions and timing for the serial port
package dsp_pkg;
    // Register offsets on the 3-bit I/O address
    localparam logic [2:0] OFS_DATA = 3'h0;   // Receive/transmit data, divisor low
    localparam logic [2:0] OFS_DIVH = 3'h1;   // Divisor high byte
    localparam logic [2:0] OFS_IID  = 3'h2;   // Interrupt source id
    localparam logic [2:0] OFS_LFC  = 3'h3;   // Line format control
    localparam logic [2:0] OFS_HOC  = 3'h4;   // Handshake output control
    localparam logic [2:0] OFS_LSF  = 3'h5;   // Line state flags

    // Field positions
    localparam int LFC_DAS_BIT   = 7;         // Divisor access select
    localparam int LFC_BREAK_BIT = 6;         // Force line low
    localparam int LFC_STOP_BIT  = 2;         // Two stop bits
    localparam int HOC_RTS_BIT   = 1;         // Request to send
    localparam int HOC_IRQEN_BIT = 3;         // Interrupt gate
    localparam int LSF_DR_BIT    = 0;         // Data ready
    localparam int LSF_OE_BIT    = 1;         // Overrun
    localparam int LSF_FE_BIT    = 3;         // Framing error
    localparam int LSF_THRE_BIT  = 5;         // Holding register empty
    localparam int LSF_TEMT_BIT  = 6;         // Transmitter idle

    // Identification values and reset values
    localparam logic [7:0]  IID_RX_AVAIL = 8'h04;
    localparam logic [7:0]  IID_NONE     = 8'h01;
    localparam logic [7:0]  LFC_RST      = 8'h00;
    localparam logic [7:0]  HOC_RST      = 8'h00;
    localparam logic [15:0] DIV_RST      = 16'h000c;

    // Timing: reference clock 1.8432 MHz made from the 25 MHz core clock
    localparam int unsigned CORE_CLK_HZ = 25000000;
    localparam int unsigned REF_CLK_HZ  = 1843200;
    localparam logic [25:0] ACC_STEP    = 26'(REF_CLK_HZ);
    localparam logic [25:0] ACC_WRAP    = 26'(CORE_CLK_HZ);
    localparam int unsigned REF_GAP_MIN = CORE_CLK_HZ / REF_CLK_HZ;
    localparam int unsigned REF_GAP_MAX = (CORE_CLK_HZ + REF_CLK_HZ - 1) / REF_CLK_HZ;
    localparam logic [3:0]  OVS_LAST    = 4'hf;   // 16 ticks per bit
    localparam logic [3:0]  OVS_MID     = 4'h7;   // Start bit middle check

    // Transmit and receive states
    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } dsp_tx_st_t;
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } dsp_rx_st_t;
endpackage

// *** hw/dsp_uart.sv ***
// Serial port core: I/O registers, baud generator, transmitter, receiver
// Function
// - Divisor select bit 7 remaps offsets 0,1
// - Divisor loads as low, high bytes
// - Bit rate is 1.8432 MHz/(16*divisor)
// - Divisors 12,48,96,1 give standard rates
// - Format bits 1:0 give length minus five
// - Format bit 2 selects two stop bits
// - Format bits 3-6 parity/break, keep zero
// - Control bit 1 drives request-to-send
// - Control bit 3 gates interrupt request
// - Status bit 0 shows received data
// - Source id reads 4 or 1
// - Status bit 5 shows holding empty
`timescale 1ns/100ps
`default_nettype none
module dsp_uart
    import dsp_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Host I/O bus
    input  wire logic [2:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    output logic            io_irq,
    // Serial line
    input  wire logic       ser_rx,
    output logic            ser_tx,
    output logic            ser_rts
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    logic [7:0]  lfc_reg, lfc_next;
    logic [7:0]  hoc_reg, hoc_next;
    logic [15:0] div_reg, div_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic [7:0]  rbuf_reg;
    logic        dr_reg, oe_reg, fe_reg;
    logic        thr_full_reg;
    logic        tx_busy;
    logic [7:0]  lsf_val;
    logic        das;
    logic        rd_data, wr_data, rd_lsf;

    assign das     = lfc_reg[LFC_DAS_BIT];
    assign rd_data = io_rd && io_addr == OFS_DATA && !das;
    assign wr_data = io_wr && io_addr == OFS_DATA && !das;
    assign rd_lsf  = io_rd && io_addr == OFS_LSF;

    // Status byte; reserved bits read zero
    always_comb begin
        lsf_val = 8'h00;
        lsf_val[LSF_DR_BIT]   = dr_reg;
        lsf_val[LSF_OE_BIT]   = oe_reg;
        lsf_val[LSF_FE_BIT]   = fe_reg;
        lsf_val[LSF_THRE_BIT] = !thr_full_reg;
        lsf_val[LSF_TEMT_BIT] = !thr_full_reg && !tx_busy;
    end

    // Register writes and read data capture
    always_comb begin
        lfc_next   = lfc_reg;
        hoc_next   = hoc_reg;
        div_next   = div_reg;
        rdata_next = rdata_reg;
        if (io_wr) begin
            case (io_addr)
                OFS_DATA: if (das) div_next[7:0] = io_wdata;
                OFS_DIVH: if (das) div_next[15:8] = io_wdata;
                OFS_LFC:  lfc_next = io_wdata;
                OFS_HOC:  hoc_next = io_wdata;
                default:  ;
            endcase
        end
        if (io_rd) begin
            case (io_addr)
                OFS_DATA: rdata_next = das ? div_reg[7:0] : rbuf_reg;
                OFS_DIVH: rdata_next = das ? div_reg[15:8] : 8'h00;
                OFS_IID:  rdata_next = dr_reg ? IID_RX_AVAIL : IID_NONE;
                OFS_LFC:  rdata_next = lfc_reg;
                OFS_HOC:  rdata_next = hoc_reg;
                OFS_LSF:  rdata_next = lsf_val;
                default:  rdata_next = 8'h00;                        // Unmapped offsets
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lfc_reg   <= LFC_RST;
            hoc_reg   <= HOC_RST;
            div_reg   <= DIV_RST;
            rdata_reg <= 8'h00;
        end else begin
            lfc_reg   <= lfc_next;
            hoc_reg   <= hoc_next;
            div_reg   <= div_next;
            rdata_reg <= rdata_next;
        end
    end

    assign io_rdata = rdata_reg;
    assign ser_rts  = hoc_reg[HOC_RTS_BIT];
    // Only received data raises a request, gated by the user output
    assign io_irq   = dr_reg && hoc_reg[HOC_IRQEN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Baud generator: fractional reference clock, then divide by divisor
    logic [25:0] acc_reg, acc_next;
    logic [15:0] bdiv_reg, bdiv_next;
    logic        ref_tick, tick16;

    // Reference tick jitters by one core cycle; averaged rate is exact
    assign ref_tick = (acc_reg + ACC_STEP) >= ACC_WRAP;
    assign tick16   = ref_tick && (bdiv_reg + 16'h0001 >= div_reg);

    always_comb begin
        acc_next  = ref_tick ? 26'(acc_reg + ACC_STEP - ACC_WRAP)
                             : 26'(acc_reg + ACC_STEP);
        bdiv_next = bdiv_reg;
        if (ref_tick) begin
            bdiv_next = tick16 ? 16'h0000 : 16'(bdiv_reg + 16'h0001);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acc_reg  <= 26'h0000000;
            bdiv_reg <= 16'h0000;
        end else begin
            acc_reg  <= acc_next;
            bdiv_reg <= bdiv_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    dsp_tx_st_t  tx_st_reg, tx_st_next;
    logic [7:0]  thr_reg, thr_next;
    logic        thr_full_next;
    logic [7:0]  tsh_reg, tsh_next;
    logic [3:0]  tcnt_reg, tcnt_next;
    logic [2:0]  tbit_reg, tbit_next;
    logic        tstop_reg, tstop_next;
    logic        tline_reg, tline_next;

    assign tx_busy = tx_st_reg != TX_IDLE;

    always_comb begin
        tx_st_next    = tx_st_reg;
        thr_next      = thr_reg;
        thr_full_next = thr_full_reg;
        tsh_next      = tsh_reg;
        tcnt_next     = tcnt_reg;
        tbit_next     = tbit_reg;
        tstop_next    = tstop_reg;
        case (tx_st_reg)
            TX_IDLE: if (thr_full_reg) begin
                tsh_next      = thr_reg;
                thr_full_next = 1'b0;
                tcnt_next     = 4'h0;
                tbit_next     = 3'h0;
                tstop_next    = 1'b0;
                tx_st_next    = TX_START;
            end
            TX_START: if (tick16) begin
                tcnt_next = tcnt_reg + 4'h1;
                if (tcnt_reg == OVS_LAST) tx_st_next = TX_DATA;
            end
            TX_DATA: if (tick16) begin
                tcnt_next = tcnt_reg + 4'h1;
                if (tcnt_reg == OVS_LAST) begin
                    tsh_next  = {1'b0, tsh_reg[7:1]};
                    tbit_next = tbit_reg + 3'h1;
                    if (tbit_reg == {1'b1, lfc_reg[1:0]}) tx_st_next = TX_STOP;
                end
            end
            TX_STOP: if (tick16) begin
                tcnt_next = tcnt_reg + 4'h1;
                if (tcnt_reg == OVS_LAST) begin
                    if (lfc_reg[LFC_STOP_BIT] && !tstop_reg) tstop_next = 1'b1;
                    else tx_st_next = TX_IDLE;
                end
            end
            default: tx_st_next = TX_IDLE;
        endcase
        // A host write in the load cycle still lands: set wins over clear
        if (wr_data) begin
            thr_next      = io_wdata;
            thr_full_next = 1'b1;
        end
        // Line level: start low, data LSB first, stop and idle high
        case (tx_st_next)
            TX_START: tline_next = 1'b0;
            TX_DATA:  tline_next = tsh_next[0];
            default:  tline_next = 1'b1;
        endcase
        if (lfc_reg[LFC_BREAK_BIT]) tline_next = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_st_reg    <= TX_IDLE;
            thr_reg      <= 8'h00;
            thr_full_reg <= 1'b0;
            tsh_reg      <= 8'h00;
            tcnt_reg     <= 4'h0;
            tbit_reg     <= 3'h0;
            tstop_reg    <= 1'b0;
            tline_reg    <= 1'b1;
        end else begin
            tx_st_reg    <= tx_st_next;
            thr_reg      <= thr_next;
            thr_full_reg <= thr_full_next;
            tsh_reg      <= tsh_next;
            tcnt_reg     <= tcnt_next;
            tbit_reg     <= tbit_next;
            tstop_reg    <= tstop_next;
            tline_reg    <= tline_next;
        end
    end

    assign ser_tx = tline_reg;

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    logic        rx_s1_reg, rx_s2_reg;
    dsp_rx_st_t  rx_st_reg, rx_st_next;
    logic [7:0]  rsh_reg, rsh_next;
    logic [3:0]  rcnt_reg, rcnt_next;
    logic [2:0]  rbit_reg, rbit_next;
    logic [7:0]  rbuf_next;
    logic        dr_next, oe_next, fe_next;
    logic        rx_done;

    always_comb begin
        rx_st_next = rx_st_reg;
        rsh_next   = rsh_reg;
        rcnt_next  = rcnt_reg;
        rbit_next  = rbit_reg;
        rbuf_next  = rbuf_reg;
        dr_next    = dr_reg;
        oe_next    = oe_reg;
        fe_next    = fe_reg;
        rx_done    = 1'b0;
        // Host side clears first so that a same-cycle event wins
        if (rd_data) dr_next = 1'b0;
        if (rd_lsf) begin
            oe_next = 1'b0;
            fe_next = 1'b0;
        end
        case (rx_st_reg)
            RX_IDLE: if (tick16 && !rx_s2_reg) begin
                rcnt_next  = 4'h0;
                rx_st_next = RX_START;
            end
            RX_START: if (tick16) begin
                rcnt_next = rcnt_reg + 4'h1;
                if (rcnt_reg == OVS_MID) begin
                    // Glitch shorter than half a bit is dropped
                    rcnt_next  = 4'h0;
                    rbit_next  = 3'h0;
                    rx_st_next = rx_s2_reg ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: if (tick16) begin
                rcnt_next = rcnt_reg + 4'h1;
                if (rcnt_reg == OVS_LAST) begin
                    rsh_next  = {rx_s2_reg, rsh_reg[7:1]};
                    rbit_next = rbit_reg + 3'h1;
                    if (rbit_reg == {1'b1, lfc_reg[1:0]}) rx_st_next = RX_STOP;
                end
            end
            RX_STOP: if (tick16) begin
                rcnt_next = rcnt_reg + 4'h1;
                if (rcnt_reg == OVS_LAST) begin
                    rx_done    = 1'b1;
                    rbuf_next  = 8'(rsh_reg >> (2'h3 - lfc_reg[1:0]));
                    oe_next    = dr_reg || oe_next;
                    fe_next    = !rx_s2_reg || fe_next;
                    dr_next    = 1'b1;
                    rx_st_next = RX_IDLE;
                end
            end
            default: rx_st_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_st_reg <= RX_IDLE;
            rsh_reg   <= 8'h00;
            rcnt_reg  <= 4'h0;
            rbit_reg  <= 3'h0;
            rbuf_reg  <= 8'h00;
            dr_reg    <= 1'b0;
            oe_reg    <= 1'b0;
            fe_reg    <= 1'b0;
        end else begin
            rx_s1_reg <= ser_rx;
            rx_s2_reg <= rx_s1_reg;
            rx_st_reg <= rx_st_next;
            rsh_reg   <= rsh_next;
            rcnt_reg  <= rcnt_next;
            rbit_reg  <= rbit_next;
            rbuf_reg  <= rbuf_next;
            dr_reg    <= dr_next;
            oe_reg    <= oe_next;
            fe_reg    <= fe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions and their helper logic
    logic [7:0] ref_gap_reg;
    logic       ref_seen_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ref_gap_reg  <= 8'h00;
            ref_seen_reg <= 1'b0;
        end else begin
            ref_gap_reg  <= ref_tick ? 8'h01 : 8'(ref_gap_reg + 8'h01);
            ref_seen_reg <= ref_seen_reg || ref_tick;
        end
    end

    ref_rate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ref_tick && ref_seen_reg |-> ref_gap_reg >= 8'(REF_GAP_MIN) && ref_gap_reg <= 8'(REF_GAP_MAX))
        else $error("reference tick spacing wrong");
    div_map_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        io_rd && io_addr == OFS_DATA && das |=> io_rdata == $past(div_reg[7:0]))
        else $error("divisor low not read back");
    div_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        io_wr && io_addr == OFS_DIVH && das |=> div_reg[15:8] == $past(io_wdata))
        else $error("divisor high not loaded");
    rts_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        io_wr && io_addr == OFS_HOC |=> ser_rts == $past(io_wdata[HOC_RTS_BIT]))
        else $error("request to send not following control");
    irq_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_done && hoc_reg[HOC_IRQEN_BIT] && !io_wr |=> io_irq)
        else $error("interrupt not raised by received data");
    iid_value_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        io_rd && io_addr == OFS_IID |=> io_rdata == ($past(dr_reg) ? IID_RX_AVAIL : IID_NONE))
        else $error("source id wrong");
    dr_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_done |=> dr_reg && rbuf_reg == $past(rbuf_next))
        else $error("data ready not set");
    rbr_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rd_data && !rx_done |=> !dr_reg)
        else $error("receive read did not clear ready");
    thre_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_data |=> !lsf_val[LSF_THRE_BIT] ##1 1'b1)
        else $error("holding empty not cleared");
    start_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_st_reg == TX_START |-> !ser_tx)
        else $error("start bit not low");
    stop_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_st_reg == TX_STOP && !lfc_reg[LFC_BREAK_BIT] |-> ser_tx)
        else $error("stop bit not high");

endmodule // dsp_uart
`default_nettype wire

// *** test/dsp_remote.sv ***
// Remote serial equipment model: frame checker and frame sender
`timescale 1ns/100ps
`default_nettype none
module dsp_remote #(
    parameter real BIT_NS = 8680.6  // One bit at divisor 1
) (
    // Serial line
    input  wire logic       ser_tx,
    output logic            ser_rx,
    // Expected frame shape
    input  wire logic [3:0] fmt_len,
    input  wire logic       fmt_two_stop,
    // Last frame seen
    output logic [7:0]      got_data,
    output logic            got_ok,
    output logic [7:0]      got_cnt
);
    // Line idles high, nothing captured yet
    initial begin
        ser_rx   = 1'b1;
        got_data = 8'h00;
        got_ok   = 1'b0;
        got_cnt  = 8'h00;
    end

    // Mid-bit sampling; a short low glitch is not taken as a frame
    always begin : rx_frame
        logic [7:0] d;
        logic       ok;
        @(negedge ser_tx);
        #(BIT_NS / 2.0);
        if (ser_tx === 1'b0) begin
            d  = 8'h00;
            ok = 1'b1;
            for (int i = 0; i < fmt_len; i++) begin
                #(BIT_NS);
                d[i] = ser_tx;
            end
            for (int s = 0; s <= int'(fmt_two_stop); s++) begin
                #(BIT_NS);
                ok = ok & (ser_tx === 1'b1);
            end
            got_data = d;
            got_ok   = ok;
            got_cnt  = got_cnt + 8'h01;
        end
    end

    // One frame, LSB first, one stop bit, then idle high
    task automatic send(input logic [7:0] b, input int nb);
        ser_rx = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < nb; i++) begin
            ser_rx = b[i];
            #(BIT_NS);
        end
        ser_rx = 1'b1;
        #(BIT_NS);
    endtask
endmodule  // dsp_remote
`default_nettype wire

// *** test/test_differential_serial_port_uart.sv ***
// Self-checking bench: registers, transmit, receive and bit timing
`timescale 1ns/100ps
`default_nettype none
module test_differential_serial_port_uart
    import dsp_pkg::*;
;
    // Design ports
    logic       core_clk;
    logic       sys_rst;
    logic [2:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       io_irq;
    logic       ser_rx;
    logic       ser_tx;
    logic       ser_rts;
    // Partner side and bookkeeping
    logic [3:0] fmt_len;
    logic       fmt_two_stop;
    logic [7:0] got_data;
    logic       got_ok;
    logic [7:0] got_cnt;
    logic [7:0] rv;
    logic [7:0] exp_b;
    logic [7:0] cnt;
    int         n_mismatch;
    int         tests_run;
    int         divs [4] = '{1, 12, 48, 96};

    dsp_uart uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_irq(io_irq),
        .ser_rx(ser_rx), .ser_tx(ser_tx), .ser_rts(ser_rts)
    );
    dsp_remote rem (
        .ser_tx(ser_tx), .ser_rx(ser_rx), .fmt_len(fmt_len), .fmt_two_stop(fmt_two_stop),
        .got_data(got_data), .got_ok(got_ok), .got_cnt(got_cnt)
    );

    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One-cycle strobes; the gap cycle keeps strobes from merging
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge core_clk);
        io_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge core_clk);
        io_rd   <= 1'b0;
        @(negedge core_clk);
        d = io_rdata;
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string what);
        rd(a, rv);
        check(rv & m, e, what);
    endtask

    // Poll status until masked value matches; a stall ends the run
    task automatic wait_lsr(input logic [7:0] m, input logic [7:0] v);
        int k;
        k = 0;
        rd(OFS_LSF, rv);
        while ((rv & m) !== v && k < 9000) begin
            rd(OFS_LSF, rv);
            k++;
        end
        if ((rv & m) !== v) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: status wait ran out", $time);
            end_of_test();
        end
    endtask

    // Data bit 0 length in core cycles; the start bit is cut short by the tick phase
    task automatic bit_time(input int d);
        int  k;
        int  hung;
        real e;
        e    = 16.0 * d * CORE_CLK_HZ / REF_CLK_HZ;
        hung = 0;
        k    = 0;
        while (ser_tx !== 1'b0 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        hung = hung + int'(k >= 100);
        k    = 0;
        while (ser_tx !== 1'b1 && k < 30000) begin
            @(negedge core_clk);
            k++;
        end
        hung = hung + int'(k >= 30000);
        k    = 0;
        while (ser_tx === 1'b1 && k < 30000) begin
            @(negedge core_clk);
            k++;
        end
        hung = hung + int'(k >= 30000);
        check({7'h00, (k > e - 16.0 && k < e + 16.0)}, 8'h01, "data bit length");
        if (hung != 0) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: bit time wait ran out", $time);
            end_of_test();
        end
    endtask

    ////////////////////////////////////////
    initial begin
        sys_rst      = 1'b1;
        io_addr      = 3'h0;
        io_wr        = 1'b0;
        io_rd        = 1'b0;
        io_wdata     = 8'h00;
        fmt_len      = 4'h8;
        fmt_two_stop = 1'b0;
        n_mismatch   = 0;
        tests_run    = 0;
        cnt          = 8'h00;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        // Reset state, read-only and unmapped places
        check({7'h00, ser_tx}, 8'h01, "idle line");
        check({7'h00, ser_rts}, 8'h00, "rts reset");
        rdc(OFS_LSF, 8'hff, 8'h60, "status reset");
        rdc(OFS_IID, 8'hff, IID_NONE, "no source");
        rdc(3'h6, 8'hff, 8'h00, "unmapped");
        wr(OFS_LSF, 8'hff);
        rdc(OFS_LSF, 8'hff, 8'h60, "status read-only");
        // Divisor latch behind the select bit
        wr(OFS_LFC, 8'h80);
        rdc(OFS_DATA, 8'hff, DIV_RST[7:0], "divisor low reset");
        rdc(OFS_DIVH, 8'hff, DIV_RST[15:8], "divisor high reset");
        wr(OFS_DATA, 8'h34);
        wr(OFS_DIVH, 8'h12);
        rdc(OFS_DATA, 8'hff, 8'h34, "divisor low");
        rdc(OFS_DIVH, 8'hff, 8'h12, "divisor high");
        wr(OFS_DATA, 8'h01);
        wr(OFS_DIVH, 8'h00);
        wr(OFS_LFC, 8'h03);
        rdc(OFS_DIVH, 8'hff, 8'h00, "high without select");
        rdc(OFS_LFC, 8'hff, 8'h03, "format");
        rd(OFS_DATA, rv);
        rd(OFS_DATA, rv);
        // Every length and stop count
        for (int f = 0; f < 8; f++) begin
            fmt_len      = 4'(5 + f % 4);
            fmt_two_stop = f[2];
            exp_b        = (8'ha5 ^ 8'(f * 17)) & (8'hff >> (3 - f % 4));
            wr(OFS_LFC, 8'(f));
            wr(OFS_DATA, 8'ha5 ^ 8'(f * 17));
            cnt = cnt + 8'h01;
            wait_lsr(8'h40, 8'h00);
            wait_lsr(8'h60, 8'h60);
            check(got_cnt, cnt, "frames seen");
            check(got_data, exp_b, "frame data");
            check({7'h00, got_ok}, 8'h01, "stop bits");
        end
        // Back to back: second character waits in the holding register
        wr(OFS_DATA, 8'h3c);
        wr(OFS_DATA, 8'hc3);
        rdc(OFS_LSF, 8'h60, 8'h00, "holding full");
        cnt = cnt + 8'h02;
        wait_lsr(8'h60, 8'h60);
        check(got_cnt, cnt, "both frames");
        check(got_data, 8'hc3, "second frame");
        // Receive with the interrupt gate open
        fmt_len      = 4'h8;
        fmt_two_stop = 1'b0;
        wr(OFS_LFC, 8'h03);
        wr(OFS_HOC, 8'h0a);
        rdc(OFS_IID, 8'hff, IID_NONE, "none pending");
        rem.send(8'h5a, 8);
        wait_lsr(8'h01, 8'h01);
        check({7'h00, io_irq}, 8'h01, "irq raised");
        check({7'h00, ser_rts}, 8'h01, "rts on");
        rdc(OFS_IID, 8'hff, IID_RX_AVAIL, "rx source");
        rdc(OFS_DATA, 8'hff, 8'h5a, "rx data");
        rdc(OFS_LSF, 8'h01, 8'h00, "ready cleared");
        check({7'h00, io_irq}, 8'h00, "irq cleared");
        // Gate closed, bit 2 alone; short character right-aligned
        wr(OFS_LFC, 8'h00);
        wr(OFS_HOC, 8'h04);
        rem.send(8'hf3, 5);
        wait_lsr(8'h01, 8'h01);
        check({7'h00, io_irq}, 8'h00, "irq gated");
        check({7'h00, ser_rts}, 8'h00, "rts off");
        rdc(OFS_DATA, 8'hff, 8'h13, "short rx");
        // Break bit holds the line low while set
        wr(OFS_LFC, 8'h40);
        repeat (2) @(negedge core_clk);
        check({7'h00, ser_tx}, 8'h00, "break forces low");
        // Bit period per divisor; reset aborts each long frame
        foreach (divs[i]) begin
            wr(OFS_LFC, 8'h80);
            wr(OFS_DATA, 8'(divs[i]));
            wr(OFS_DIVH, 8'h00);
            wr(OFS_LFC, 8'h03);
            wr(OFS_DATA, 8'h55);
            bit_time(divs[i]);
            @(posedge core_clk);
            sys_rst <= 1'b1;
            repeat (2) @(posedge core_clk);
            sys_rst <= 1'b0;
        end
        rdc(OFS_LSF, 8'hff, 8'h60, "idle after abort");
        end_of_test();
    end
endmodule  // test_differential_serial_port_uart
`default_nettype wire
